// ===== rtl/msbg_pkg.sv
// constants shared by the mode, status and buffer gate logic
package msbg_pkg;
   localparam logic [7:0] ADDR_DEVICE_ID   = 8'h13;
   localparam logic [7:0] ADDR_MODE_STATUS = 8'h14;
   // identifier value is arbitrary, not a real product code
   localparam logic [7:0] DEVICE_ID_VALUE  = 8'h5a;
   localparam int         ERR_BIT_POS      = 7;
   localparam int         CNT_LSB_POS      = 2;
   localparam int         CNT_WIDTH        = 5;
   localparam logic [4:0] CNT_RESET        = 5'h00;
   localparam logic [4:0] CNT_MAX          = 5'h1f;
   localparam logic [1:0] MODE_STANDBY     = 2'h0;
   localparam logic [1:0] MODE_WAKE        = 2'h1;
   localparam logic [1:0] MODE_SLEEP       = 2'h2;
   localparam logic [1:0] MODE_EXTERNAL_TRIGGER_MODE    = 2'h3;
   localparam logic [1:0] BUF_MODE_OFF     = 2'h0;
   localparam logic [7:0] READ_DATA_RESET  = 8'h00;
endpackage

// ===== rtl/msbg_status.sv
// mode reporting, buffer gate error tracking and register read port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module msbg_status (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       bootModePin,
   input  wire logic       motionDetectSelect,
   input  wire logic [1:0] requestedMode,
   input  wire logic       secondPinTriggerSelect,
   input  wire logic       measureBusy,
   input  wire logic       bufferGateEnable,
   input  wire logic       sampleStrobe,
   input  wire logic [5:0] bufferSampleCount,
   input  wire logic       bufferFlush,
   input  wire logic [1:0] bufferOperatingMode,
   input  wire logic       wakeStateOutputEnable,
   input  wire logic       wakeOutputPinSelect,
   input  wire logic       interruptPolarity,
   input  wire logic       softResetRequest,
   input  wire logic       serialBusy,
   input  wire logic       readStrobe,
   input  wire logic [7:0] readAddr,
   output logic [7:0]      readData,
   output logic [1:0]      operatingModeField,
   output logic            bufferGateError,
   output logic [4:0]      bufferGatePeriodCount,
   output logic            bufferDiscard,
   output logic            debounceReset,
   output logic            firstIntPinLevel,
   output logic            firstIntPinDrive,
   output logic            secondIntPinLevel,
   output logic            secondIntPinDrive,
   output logic            softResetStart
);

   // ----------------------------------------------------------------
   // pin synchroniser for the boot strap
   // ----------------------------------------------------------------
   logic [2:0] bootSync_r;
   logic [2:0] syncFill_r;
   logic       bootHigh_r;
   logic       strapDone_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bootSync_r <= 3'h0;
         syncFill_r <= 3'h0;
      end else begin
         bootSync_r <= {bootSync_r[1:0], bootModePin};
         syncFill_r <= {syncFill_r[1:0], 1'b1};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bootHigh_r <= 1'b0;
      end else if (bootSync_r[1] == bootSync_r[2]) begin
         bootHigh_r <= bootSync_r[2];
      end
   end

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   logic [1:0] mode_r;
   logic [1:0] mode_nxt;

   always_comb begin
      mode_nxt = requestedMode;
      if (secondPinTriggerSelect && !bootHigh_r) begin
         mode_nxt = measureBusy ? msbg_pkg::MODE_WAKE : msbg_pkg::MODE_EXTERNAL_TRIGGER_MODE;
      end else if (requestedMode == msbg_pkg::MODE_EXTERNAL_TRIGGER_MODE) begin
         mode_nxt = msbg_pkg::MODE_STANDBY;
      end
      if (bootHigh_r && mode_nxt == msbg_pkg::MODE_EXTERNAL_TRIGGER_MODE) begin
         mode_nxt = msbg_pkg::MODE_WAKE;
      end
   end

   // strap is captured a few cycles after reset release once synchronised
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_r      <= msbg_pkg::MODE_STANDBY;
         strapDone_r <= 1'b0;
      end else if (!strapDone_r) begin
         // wait until every stage holds a pin sample, never read the raw pin
         if (syncFill_r[2] && bootSync_r[1] == bootSync_r[2]) begin
            strapDone_r <= 1'b1;
            mode_r      <= (bootSync_r[2] && motionDetectSelect) ?
                           msbg_pkg::MODE_WAKE : msbg_pkg::MODE_STANDBY;
         end
      end else begin
         mode_r <= mode_nxt;
      end
   end

   wire standbyToActive = strapDone_r && mode_r == msbg_pkg::MODE_STANDBY
                          && mode_nxt != msbg_pkg::MODE_STANDBY;

   // ----------------------------------------------------------------
   // buffer gate error and period count
   // ----------------------------------------------------------------
   logic gateErr_r;
   logic [4:0] gateCnt_r;
   wire clearGate = bufferSampleCount == 6'h00 || bufferFlush
                    || bufferOperatingMode == msbg_pkg::BUF_MODE_OFF
                    || standbyToActive;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gateErr_r <= 1'b0;
      end else if (clearGate) begin
         gateErr_r <= 1'b0;
      end else if (bufferGateEnable && sampleStrobe) begin
         gateErr_r <= 1'b1;
      end // holds otherwise
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gateCnt_r <= msbg_pkg::CNT_RESET;
      end else if (clearGate) begin
         gateCnt_r <= msbg_pkg::CNT_RESET;
      end else if (gateErr_r && sampleStrobe && gateCnt_r != msbg_pkg::CNT_MAX) begin
         gateCnt_r <= gateCnt_r + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // side effects of mode changes
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bufferDiscard <= 1'b0;
         debounceReset <= 1'b0;
      end else begin
         bufferDiscard <= standbyToActive
                          || bufferOperatingMode == msbg_pkg::BUF_MODE_OFF;
         debounceReset <= strapDone_r && mode_nxt != mode_r
                          && mode_nxt != msbg_pkg::MODE_STANDBY;
      end
   end

   // wake state output, drive enable low while driving
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         firstIntPinLevel  <= 1'b0;
         firstIntPinDrive  <= 1'b1;
         secondIntPinLevel <= 1'b0;
         secondIntPinDrive <= 1'b1;
      end else begin
         firstIntPinLevel  <= !interruptPolarity;
         secondIntPinLevel <= !interruptPolarity;
         firstIntPinDrive  <= !(wakeStateOutputEnable && mode_r == msbg_pkg::MODE_WAKE
                                && !wakeOutputPinSelect);
         secondIntPinDrive <= !(wakeStateOutputEnable && mode_r == msbg_pkg::MODE_WAKE
                                && wakeOutputPinSelect);
      end
   end

   // soft reset held until the serial bus is idle
   logic resetWait_r;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         softResetStart <= 1'b0;
      end else begin
         softResetStart <= (resetWait_r || softResetRequest) && !serialBusy;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         resetWait_r <= 1'b0;
      end else begin
         resetWait_r <= (resetWait_r || softResetRequest) && serialBusy;
      end
   end

   // ----------------------------------------------------------------
   // register read port and status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         readData <= msbg_pkg::READ_DATA_RESET;
      end else if (readStrobe) begin
         unique case (readAddr)
            msbg_pkg::ADDR_DEVICE_ID:   readData <= msbg_pkg::DEVICE_ID_VALUE;
            msbg_pkg::ADDR_MODE_STATUS: readData <= {gateErr_r, gateCnt_r, mode_r};
            default:                    readData <= msbg_pkg::READ_DATA_RESET;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         operatingModeField    <= msbg_pkg::MODE_STANDBY;
         bufferGateError       <= 1'b0;
         bufferGatePeriodCount <= msbg_pkg::CNT_RESET;
      end else begin
         operatingModeField    <= mode_r;
         bufferGateError       <= gateErr_r;
         bufferGatePeriodCount <= gateCnt_r;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_errSeen;
      gateErr_r && !clearGate;
   endsequence

   a_id_constant: assert property (@(posedge sys_clk) disable iff (rst)
      readStrobe && readAddr == msbg_pkg::ADDR_DEVICE_ID |=> readData == msbg_pkg::DEVICE_ID_VALUE)
      else $error("identifier read wrong");
   a_no_trig_boot: assert property (@(posedge sys_clk) disable iff (rst)
      bootHigh_r && strapDone_r |=> mode_r != msbg_pkg::MODE_EXTERNAL_TRIGGER_MODE)
      else $error("trigger mode with boot pin high");
   a_err_set: assert property (@(posedge sys_clk) disable iff (rst)
      bufferGateEnable && sampleStrobe && !clearGate |=> gateErr_r)
      else $error("gate error not set");
   a_err_hold: assert property (@(posedge sys_clk) disable iff (rst)
      s_errSeen |=> gateErr_r)
      else $error("gate error dropped");
   a_err_clear: assert property (@(posedge sys_clk) disable iff (rst)
      clearGate |=> !gateErr_r && gateCnt_r == 5'h00)
      else $error("gate error not cleared");
   a_cnt_step: assert property (@(posedge sys_clk) disable iff (rst)
      s_errSeen ##0 (sampleStrobe && gateCnt_r != msbg_pkg::CNT_MAX)
      |=> gateCnt_r == $past(gateCnt_r) + 5'h01)
      else $error("period count did not step");
   a_cnt_sat: assert property (@(posedge sys_clk) disable iff (rst)
      gateCnt_r == 5'h1f && !clearGate |=> gateCnt_r == 5'h1f)
      else $error("period count wrapped");
   a_reset_wait: assert property (@(posedge sys_clk) disable iff (rst)
      serialBusy |=> !softResetStart)
      else $error("soft reset during transaction");
   a_wake_drive: assert property (@(posedge sys_clk) disable iff (rst)
      !(wakeStateOutputEnable && mode_r == msbg_pkg::MODE_WAKE)
      |=> firstIntPinDrive && secondIntPinDrive)
      else $error("wake output driven outside wake");

   // strap capture, trigger reporting and mode entry
   sequence s_strapCapture;
      !strapDone_r && syncFill_r[2] && bootSync_r[1] == bootSync_r[2];
   endsequence

   sequence s_trigWait;
      strapDone_r && secondPinTriggerSelect && !bootHigh_r;
   endsequence

   a_strap_low: assert property (@(posedge sys_clk) disable iff (rst)
      s_strapCapture ##0 !bootSync_r[2] |=> mode_r == msbg_pkg::MODE_STANDBY)
      else $error("strap low did not give standby");
   a_strap_wake: assert property (@(posedge sys_clk) disable iff (rst)
      s_strapCapture ##0 (bootSync_r[2] && motionDetectSelect)
      |=> mode_r == msbg_pkg::MODE_WAKE)
      else $error("strap high did not give wake");
   a_trig_wait: assert property (@(posedge sys_clk) disable iff (rst)
      s_trigWait ##0 !measureBusy |=> mode_r == msbg_pkg::MODE_EXTERNAL_TRIGGER_MODE)
      else $error("trigger wait not reported");
   a_trig_meas: assert property (@(posedge sys_clk) disable iff (rst)
      s_trigWait ##0 measureBusy |=> mode_r == msbg_pkg::MODE_WAKE)
      else $error("triggered measurement not reported as wake");
   a_deb_entry: assert property (@(posedge sys_clk) disable iff (rst)
      $past(strapDone_r) && $changed(mode_r) && mode_r != msbg_pkg::MODE_STANDBY
      |-> debounceReset)
      else $error("debounce reset missing on mode entry");

   // gate count, buffer discard, pins, read port and mode field
   a_cnt_hold: assert property (@(posedge sys_clk) disable iff (rst)
      gateErr_r && !sampleStrobe && !clearGate |=> $stable(gateCnt_r))
      else $error("period count moved without a sample");
   a_discard_off: assert property (@(posedge sys_clk) disable iff (rst)
      bufferOperatingMode == msbg_pkg::BUF_MODE_OFF |=> bufferDiscard)
      else $error("buffer not discarded while off");
   a_level_pol: assert property (@(posedge sys_clk) disable iff (rst)
      !rst |=> firstIntPinLevel == !$past(interruptPolarity)
      && secondIntPinLevel == !$past(interruptPolarity))
      else $error("wake level ignores polarity");
   a_first_drive: assert property (@(posedge sys_clk) disable iff (rst)
      wakeStateOutputEnable && mode_r == msbg_pkg::MODE_WAKE && !wakeOutputPinSelect
      |=> !firstIntPinDrive && secondIntPinDrive)
      else $error("first pin not driven in wake");
   a_second_drive: assert property (@(posedge sys_clk) disable iff (rst)
      wakeStateOutputEnable && mode_r == msbg_pkg::MODE_WAKE && wakeOutputPinSelect
      |=> firstIntPinDrive && !secondIntPinDrive)
      else $error("second pin not driven in wake");
   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
      readStrobe && readAddr != msbg_pkg::ADDR_DEVICE_ID
      && readAddr != msbg_pkg::ADDR_MODE_STATUS |=> readData == msbg_pkg::READ_DATA_RESET)
      else $error("unmapped read not zero");
   a_mode_report: assert property (@(posedge sys_clk) disable iff (rst)
      !rst |=> operatingModeField == $past(mode_r))
      else $error("mode field does not follow mode");

endmodule

// ===== testbench/msbg_host.sv
// host model that reads device registers over the register read port
module msbg_host (
   input  wire logic       sys_clk,
   input  wire logic [7:0] readData,
   output logic            readStrobe,
   output logic [7:0]      readAddr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      readStrobe = 1'b0;
      readAddr   = 8'hff;
   end
   // one read; the bench polls the mode byte this way
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      readStrobe <= 1'b1;
      readAddr   <= a;
      @(posedge sys_clk);
      readStrobe <= 1'b0;
      readAddr   <= ~a;
      @(posedge sys_clk);
      #1 d = readData;
   endtask
endmodule

// ===== testbench/mode_status_and_buffer_gate_tb.sv
// self-checking bench for the mode, status and buffer gate logic
module mode_status_and_buffer_gate_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------
   // signals, model state and design
   // ------------------------------------------------
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        bootModePin, motionDetectSelect, secondPinTriggerSelect, measureBusy;
   logic        bufferGateEnable, sampleStrobe, bufferFlush, wakeStateOutputEnable;
   logic        wakeOutputPinSelect, interruptPolarity, softResetRequest, serialBusy;
   logic        readStrobe, bufferGateError, bufferDiscard, debounceReset, softResetStart;
   logic        firstIntPinLevel, firstIntPinDrive, secondIntPinLevel, secondIntPinDrive;
   logic [1:0]  requestedMode, bufferOperatingMode, operatingModeField;
   logic [5:0]  bufferSampleCount;
   logic [4:0]  bufferGatePeriodCount;
   logic [7:0]  readAddr, readData, rdv;
   logic [31:0] rnd;
   int          errors = 0, n_compared = 0, seed = 32'h2444fc94;
   int          expMode = 0, expErr = 0, expCnt = 0, i, d0, nDeb = 0, nDisc = 0;
   int          modeSeq[3] = '{1, 2, 0};
   always #2 sys_clk = ~sys_clk;
   always @(negedge sys_clk) begin
      nDeb += (debounceReset === 1'b1);
      nDisc += (bufferDiscard === 1'b1);
   end
   msbg_status dut (
      .sys_clk, .rst, .bootModePin, .motionDetectSelect, .requestedMode,
      .secondPinTriggerSelect, .measureBusy, .bufferGateEnable, .sampleStrobe,
      .bufferSampleCount, .bufferFlush, .bufferOperatingMode, .wakeStateOutputEnable,
      .wakeOutputPinSelect, .interruptPolarity, .softResetRequest, .serialBusy,
      .readStrobe, .readAddr, .readData, .operatingModeField, .bufferGateError,
      .bufferGatePeriodCount, .bufferDiscard, .debounceReset, .firstIntPinLevel,
      .firstIntPinDrive, .secondIntPinLevel, .secondIntPinDrive, .softResetStart
   );
   msbg_host host (.sys_clk, .readData, .readStrobe, .readAddr);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic status();
      cyc(8);
      host.rd(msbg_pkg::ADDR_MODE_STATUS, rdv);
      chk("status", {expErr[0], expCnt[4:0], expMode[1:0]}, rdv);
      chk("modeField", {6'h00, expMode[1:0]}, {6'h00, operatingModeField});
      chk("errFlag", {7'h00, expErr[0]}, {7'h00, bufferGateError});
      chk("periodCnt", {3'h0, expCnt[4:0]}, {3'h0, bufferGatePeriodCount});
   endtask
   task automatic mode(input logic [1:0] r, input logic t, input logic b, input int e);
      @(posedge sys_clk);
      requestedMode <= r;
      secondPinTriggerSelect <= t;
      measureBusy <= b;
      expMode = e;
      status();
   endtask
   // sample periods; the model follows set, count and saturation
   task automatic strobe(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         sampleStrobe <= 1'b1;
         @(posedge sys_clk);
         sampleStrobe <= 1'b0;
         if (bufferGateEnable && bufferSampleCount != 0) begin
            if (expErr == 1) expCnt = (expCnt < 31) ? expCnt + 1 : 31;
            expErr = 1;
         end
      end
   endtask
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(40000);
      errors++;
      summarize();
   end
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      {bootModePin, motionDetectSelect, secondPinTriggerSelect, measureBusy, bufferGateEnable,
       sampleStrobe, bufferFlush, softResetRequest, serialBusy} = '0;
      wakeStateOutputEnable = 1'b1;
      rnd = $random(seed);
      {wakeOutputPinSelect, interruptPolarity} = rnd[1:0];
      requestedMode = 2'h0;
      bufferOperatingMode = 2'h1;
      bufferSampleCount = {1'b0, rnd[6:2]} + 6'h01;
      cyc(5);
      rst <= 1'b0;
      status();
      host.rd(msbg_pkg::ADDR_DEVICE_ID, rdv);
      chk("ident", msbg_pkg::DEVICE_ID_VALUE, rdv);
      host.rd(8'h20, rdv);
      chk("unmapped", 8'h00, rdv);
      for (i = 0; i < 3; i++) begin
         d0 = nDeb;
         mode(modeSeq[i][1:0], 1'b0, 1'b0, modeSeq[i]);
         chk("debounce", {7'h00, modeSeq[i] != 0}, {7'h00, nDeb != d0});
      end
      mode(2'h3, 1'b1, 1'b0, 3);
      mode(2'h3, 1'b1, 1'b1, 1);
      mode(2'h3, 1'b1, 1'b0, 3);
      mode(2'h1, 1'b0, 1'b0, 1);
      for (i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         {wakeOutputPinSelect, interruptPolarity} <= i[1:0];
         cyc(8);
         @(negedge sys_clk);
         chk("drive", {6'h00, ~i[1], i[1]},
             {6'h00, secondIntPinDrive, firstIntPinDrive});
         chk("level", {7'h00, ~i[0]},
             {7'h00, i[1] ? secondIntPinLevel : firstIntPinLevel});
      end
      @(posedge sys_clk);
      wakeStateOutputEnable <= 1'b0;
      cyc(4);
      @(negedge sys_clk);
      chk("driveOff", 8'h03, {6'h00, secondIntPinDrive, firstIntPinDrive});
      @(posedge sys_clk);
      wakeStateOutputEnable <= 1'b1;
      strobe(2);
      status();
      @(posedge sys_clk);
      bufferGateEnable <= 1'b1;
      strobe(36);
      status();
      for (i = 0; i < 4; i++) begin
         strobe(3);
         status();
         d0 = nDisc;
         @(posedge sys_clk);
         case (i)
            0: bufferSampleCount <= 6'h00;
            1: bufferFlush <= 1'b1;
            2: bufferOperatingMode <= msbg_pkg::BUF_MODE_OFF;
            default: requestedMode <= msbg_pkg::MODE_STANDBY;
         endcase
         @(posedge sys_clk);
         bufferFlush <= 1'b0;
         cyc(8);
         rnd = $random(seed);
         bufferSampleCount <= {1'b0, rnd[4:0]} + 6'h01;
         bufferOperatingMode <= 2'h1;
         requestedMode <= msbg_pkg::MODE_WAKE;
         expErr = 0;
         expCnt = 0;
         status();
         chk("discard", {7'h00, i >= 2}, {7'h00, nDisc != d0});
      end
      @(posedge sys_clk);
      serialBusy <= 1'b1;
      softResetRequest <= 1'b1;
      @(posedge sys_clk);
      softResetRequest <= 1'b0;
      cyc(10);
      @(negedge sys_clk);
      chk("resetHeld", 8'h00, {7'h00, softResetStart});
      @(posedge sys_clk);
      serialBusy <= 1'b0;
      for (i = 0; i < 50 && softResetStart !== 1'b1; i++) @(negedge sys_clk);
      chk("resetGo", 8'h01, {7'h00, softResetStart});
      @(posedge sys_clk);
      softResetRequest <= 1'b1;
      @(posedge sys_clk);
      softResetRequest <= 1'b0;
      @(negedge sys_clk);
      chk("resetIdle", 8'h01, {7'h00, softResetStart});
      @(posedge sys_clk);
      rst <= 1'b1;
      bootModePin <= 1'b1;
      motionDetectSelect <= 1'b1;
      cyc(5);
      rst <= 1'b0;
      expErr = 0;
      expCnt = 0;
      status();
      mode(2'h3, 1'b1, 1'b0, 0);
      summarize();
   end
endmodule
